// *** pkg/sgc_pkg.sv ***
// Functional notes
// - Pass-all bit forwards bad frames too, but only while sniffer mode is active.
// - Transmit flow control cleared: no pause frames are ever generated.
// - Receive flow control cleared: received pause frames are ignored, no throttling.
// - Length check set: drop frames whose length field below 1500 mismatches real length.
// - Aging enable bit, reset one, turns address aging on or off.
// - Fast-age bit set: aging period becomes 800 microseconds.
// - Aggressive back-off bit selects non-standard back-off on half-duplex ports.
// - Pass-pause bit set: received flow control frames are forwarded, not filtered.
// - Link-change aging set: link up-to-down triggers one fast pass under 800 us.
// - After the triggered fast pass, aging returns to the 300 s period.
// - Any port unplugged: every learned address is aged out.
// - VLAN bit set enables 802.1Q VLAN mode; cleared disables it.
// - IGMP snoop bit set: every forwarded IGMP frame also goes to the host port.
// - MLD snooping happens only while the MLD enable bit is set.
// - MLD option behaviour applies only while the MLD option bit is set.
// - Priority bit: 0 strict highest first, 1 weighted 8:4:2:1 over queues 3..0.
package sgc_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int NORMAL_AGE_S  = 300;
  localparam int NORMAL_AGE_US = NORMAL_AGE_S * 1000000;
  localparam int FAST_AGE_US   = 800;
  localparam int LINK_AGE_US   = 799;
  // ==========================================================
  // Register map (index, byte address is four times the index)
  localparam logic [29:0] CTL1_IDX   = 30'h02;
  localparam logic [29:0] CTL2_IDX   = 30'h04;
  localparam logic [15:0] CTL1_RESET = 16'h3400;
  localparam logic [15:0] CTL2_RESET = 16'h0000;
  localparam logic [15:0] CTL2_MASK  = 16'hF800;
  // ==========================================================
  // Field positions
  localparam int C1_PASS_ALL   = 15;
  localparam int C1_TXFC       = 13;
  localparam int C1_RXFC       = 12;
  localparam int C1_LEN_CHK    = 11;
  localparam int C1_AGE_EN     = 10;
  localparam int C1_FAST_AGE   = 9;
  localparam int C1_AGGR_BO    = 8;
  localparam int C1_PASS_PAUSE = 3;
  localparam int C1_LINK_AGE   = 0;
  localparam int C2_VLAN       = 15;
  localparam int C2_IGMP       = 14;
  localparam int C2_MLD        = 13;
  localparam int C2_MLD_OPT    = 12;
  localparam int C2_WFQ        = 11;
  // ==========================================================
  // Frame and queue constants
  localparam logic [15:0]      MAX_LEN_FIELD = 16'h05DC;
  localparam logic [3:0][3:0]  WFQ_WEIGHT    = {4'h8, 4'h4, 4'h2, 4'h1};
endpackage : sgc_pkg

// *** design/age_timer.sv ***
`timescale 1ns/10ps
module age_timer #(
  parameter int NORMAL_TICKS = 300000000,
  parameter int FAST_TICKS   = 800,
  parameter int LINK_TICKS   = 799
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       age_en,
  input  wire logic       fast_en,
  input  wire logic       link_age_en,
  input  wire logic [1:0] link_up,
  output logic            age_pass,
  output logic            flush_all
);
  import sgc_pkg::*;
  typedef struct packed {
    logic [4:0]  div;
    logic [31:0] cnt;
    logic        one_shot;
    logic [1:0]  link_prev;
    logic        pass;
    logic        flush;
  } age_st_t;
  age_st_t s_r, s_nxt;
  logic    down;
  logic    tick;
  logic [31:0] period;

  // ==========================================================
  // Tick divider, period select and aging pass sequencing
  always_comb begin
    s_nxt           = s_r;
    s_nxt.pass      = 1'b0;
    s_nxt.flush     = 1'b0;
    s_nxt.link_prev = link_up;
    down   = |(s_r.link_prev & ~link_up);
    tick   = (s_r.div == 5'(TICK_CYCLES - 1));
    s_nxt.div = tick ? 5'h00 : s_r.div + 5'h01;
    period = fast_en ? 32'(FAST_TICKS - 1) :
             s_r.one_shot ? 32'(LINK_TICKS - 1) : 32'(NORMAL_TICKS - 1);
    if (!age_en) begin
      s_nxt.cnt = 32'h0;
    end else if (s_r.cnt > period) begin
      // Period just shortened: restart so the count never overruns it
      s_nxt.cnt = 32'h0;
    end else if (tick) begin
      if (s_r.cnt >= period) begin
        s_nxt.cnt      = 32'h0;
        s_nxt.pass     = 1'b1;
        s_nxt.one_shot = 1'b0;
      end else begin
        s_nxt.cnt = s_r.cnt + 32'h1;
      end
    end
    // Link loss: flush always, and arm one fast pass if link_age_en is set; set beats clear
    if (down) begin
      s_nxt.flush = 1'b1;
      if (link_age_en) begin
        s_nxt.one_shot = 1'b1;
        s_nxt.cnt      = 32'h0;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) s_r <= '0;
    else        s_r <= s_nxt;
  end

  assign age_pass  = s_r.pass;
  assign flush_all = s_r.flush;

  // ==========================================================
  // Checks
  property p_age_off;
    @(posedge clk) disable iff (!rst_n) !age_en |=> !age_pass;
  endproperty
  a_age_off: assert property (p_age_off) else $error("aging pass while disabled");
  property p_fast_bound;
    @(posedge clk) disable iff (!rst_n) fast_en && age_en |=> s_r.cnt < 32'(FAST_TICKS);
  endproperty
  a_fast_bound: assert property (p_fast_bound) else $error("fast age period exceeded");
  property p_link_arm;
    @(posedge clk) disable iff (!rst_n) down && link_age_en |=> s_r.one_shot && s_r.cnt == 0;
  endproperty
  a_link_arm: assert property (p_link_arm) else $error("link loss did not arm fast pass");
  property p_back_normal;
    @(posedge clk) disable iff (!rst_n) s_r.pass && !$past(down) |-> !s_r.one_shot;
  endproperty
  a_back_normal: assert property (p_back_normal) else $error("fast pass not ended");
  property p_flush;
    @(posedge clk) disable iff (!rst_n) down |=> flush_all;
  endproperty
  a_flush: assert property (p_flush) else $error("unplug did not flush table");
  c_pass: cover property (@(posedge clk) disable iff (!rst_n) age_pass);
  c_link: cover property (@(posedge clk) disable iff (!rst_n) s_r.one_shot ##1 age_pass);
endmodule : age_timer

// *** design/wfq_sched.sv ***
`timescale 1ns/10ps
module wfq_sched (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wfq_en,
  input  wire logic [3:0] q_ready,
  input  wire logic       slot,
  output logic            grant_valid,
  output logic [1:0]      grant_q
);
  import sgc_pkg::*;
  typedef struct packed {
    logic [3:0][3:0] credit;
    logic            gv;
    logic [1:0]      gq;
  } wfq_st_t;
  wfq_st_t s_r, s_nxt;
  logic [1:0] hi;
  logic [3:0] elig;
  logic [3:0] c;
  logic [1:0] pick;

  // Highest set index of a queue mask
  function automatic logic [1:0] top_of(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < 4; i++) if (m[i]) r = 2'(i);
    return r;
  endfunction : top_of

  // ==========================================================
  // Grant selection: strict priority or credit-weighted service
  always_comb begin
    s_nxt    = s_r;
    s_nxt.gv = 1'b0;
    hi       = top_of(q_ready);
    c        = 4'h0;
    for (int i = 0; i < 4; i++) elig[i] = q_ready[i] && (s_r.credit[i] != 4'h0);
    pick = top_of(elig);
    if (slot && (|q_ready)) begin
      s_nxt.gv = 1'b1;
      if (!wfq_en) begin
        s_nxt.gq = hi;
      end else begin
        // Out of credit: reload, highest busy queue takes one per idle queue
        if (elig == 4'h0) begin
          for (int i = 0; i < 4; i++) c = c + {3'h0, ~q_ready[i]};
          for (int i = 0; i < 4; i++)
            s_nxt.credit[i] = WFQ_WEIGHT[i] + ((2'(i) == hi) ? c : 4'h0);
          pick = hi;
        end
        s_nxt.gq = pick;
        s_nxt.credit[pick] = s_nxt.credit[pick] - 4'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) s_r <= '0;
    else        s_r <= s_nxt;
  end

  assign grant_valid = s_r.gv;
  assign grant_q     = s_r.gq;

  // ==========================================================
  // Checks
  property p_strict;
    @(posedge clk) disable iff (!rst_n)
      slot && (|q_ready) && !wfq_en |=> grant_valid && grant_q == $past(hi);
  endproperty
  a_strict: assert property (p_strict) else $error("strict grant not highest queue");
  c_wfq: cover property (@(posedge clk) disable iff (!rst_n)
    wfq_en && grant_valid && grant_q == 2'h0);
endmodule : wfq_sched

// *** design/switch_global_control_regs.sv ***
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
module switch_global_control_regs #(
  parameter int NORMAL_AGE_TICKS = sgc_pkg::NORMAL_AGE_US,
  parameter int FAST_AGE_TICKS   = sgc_pkg::FAST_AGE_US,
  parameter int LINK_AGE_TICKS   = sgc_pkg::LINK_AGE_US
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic [31:0]      HRDATA,
  // Frame verdict
  input  wire logic        RX_FRAME_VALID,
  input  wire logic        RX_FRAME_BAD,
  input  wire logic        RX_IS_PAUSE,
  input  wire logic        RX_IS_IGMP,
  input  wire logic        RX_IS_MLD,
  input  wire logic [15:0] RX_LEN_FIELD,
  input  wire logic [15:0] RX_ACT_LEN,
  input  wire logic        SNIFFER_ACTIVE,
  output logic             RX_FORWARD,
  output logic             RX_DROP,
  output logic             RX_TO_HOST,
  output logic             RX_PAUSE_HONOR,
  // Flow control
  input  wire logic        TX_PAUSE_REQ,
  output logic             TX_PAUSE_GEN,
  // Mode levels
  output logic             AGGR_BACKOFF_EN,
  output logic             VLAN_EN,
  output logic             MLD_SNOOP_EN,
  output logic             MLD_OPT_EN,
  // Aging
  input  wire logic [1:0]  PORT_LINK_UP,
  output logic             AGE_PASS,
  output logic             AGE_FLUSH_ALL,
  // Output queue service
  input  wire logic [3:0]  TXQ_READY,
  input  wire logic        TXQ_SLOT,
  output logic             TXQ_GRANT_VALID,
  output logic [1:0]       TXQ_GRANT_SEL
);
  import sgc_pkg::*;

  typedef struct packed {
    logic [15:0] ctl1;
    logic [15:0] ctl2;
    logic        dp_wr1;
    logic        dp_wr2;
    logic [31:0] rdata;
    logic        fwd;
    logic        drop;
    logic        host;
    logic        honor;
    logic        txp;
  } regs_st_t;

  regs_st_t   s_r, s_nxt;
  logic [1:0] rst_sync_r;
  logic       rst_n_i;
  logic       addr_ph;
  logic       hit1;
  logic       hit2;
  logic       len_err;
  logic       bad_drop;
  logic       pause_drop;
  logic       snoop;

  // ==========================================================
  // Reset release through two flops
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) rst_sync_r <= 2'h0;
    else        rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n_i = rst_sync_r[1];

  // ==========================================================
  // Bus decode: zero-wait slave, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign addr_ph   = HSEL && HREADY && HTRANS[1];
  assign hit1      = (HADDR[31:2] == CTL1_IDX) && (HADDR[1:0] == 2'h0);
  assign hit2      = (HADDR[31:2] == CTL2_IDX) && (HADDR[1:0] == 2'h0);

  // Frame classification terms
  assign len_err    = s_r.ctl1[C1_LEN_CHK] && (RX_LEN_FIELD < MAX_LEN_FIELD)
                      && (RX_LEN_FIELD != RX_ACT_LEN);
  assign bad_drop   = RX_FRAME_BAD && !(s_r.ctl1[C1_PASS_ALL] && SNIFFER_ACTIVE);
  assign pause_drop = RX_IS_PAUSE && !s_r.ctl1[C1_PASS_PAUSE];
  assign snoop      = (RX_IS_IGMP && s_r.ctl2[C2_IGMP])
                      || (RX_IS_MLD && s_r.ctl2[C2_MLD]);

  // ==========================================================
  // Next state: register writes, read data, frame verdicts
  always_comb begin
    s_nxt        = s_r;
    s_nxt.dp_wr1 = addr_ph && HWRITE && hit1;
    s_nxt.dp_wr2 = addr_ph && HWRITE && hit2;
    // Data phase write lands first so a following read sees it
    if (s_r.dp_wr1) s_nxt.ctl1 = HWDATA[15:0];
    if (s_r.dp_wr2) s_nxt.ctl2 = HWDATA[15:0] & CTL2_MASK;
    if (addr_ph && !HWRITE) begin
      s_nxt.rdata = hit1 ? {16'h0000, s_nxt.ctl1} :
                    hit2 ? {16'h0000, s_nxt.ctl2} : 32'h0000_0000;
    end
    // One verdict per offered frame, pulses otherwise low
    s_nxt.fwd   = 1'b0;
    s_nxt.drop  = 1'b0;
    s_nxt.host  = 1'b0;
    s_nxt.honor = 1'b0;
    if (RX_FRAME_VALID) begin
      s_nxt.drop  = len_err || bad_drop || pause_drop;
      s_nxt.fwd   = !(len_err || bad_drop || pause_drop);
      s_nxt.host  = s_nxt.fwd && snoop;
      s_nxt.honor = RX_IS_PAUSE && s_r.ctl1[C1_RXFC];
    end
    s_nxt.txp = TX_PAUSE_REQ && s_r.ctl1[C1_TXFC];
  end

  // State register
  always_ff @(posedge CORE_CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r      <= '0;
      s_r.ctl1 <= CTL1_RESET;
      s_r.ctl2 <= CTL2_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign HRDATA          = s_r.rdata;
  assign RX_FORWARD      = s_r.fwd;
  assign RX_DROP         = s_r.drop;
  assign RX_TO_HOST      = s_r.host;
  assign RX_PAUSE_HONOR  = s_r.honor;
  assign TX_PAUSE_GEN    = s_r.txp;
  assign AGGR_BACKOFF_EN = s_r.ctl1[C1_AGGR_BO];
  assign VLAN_EN         = s_r.ctl2[C2_VLAN];
  assign MLD_SNOOP_EN    = s_r.ctl2[C2_MLD];
  assign MLD_OPT_EN      = s_r.ctl2[C2_MLD] && s_r.ctl2[C2_MLD_OPT];

  // ==========================================================
  // Address table aging sequencer
  age_timer #(
    .NORMAL_TICKS (NORMAL_AGE_TICKS),
    .FAST_TICKS   (FAST_AGE_TICKS),
    .LINK_TICKS   (LINK_AGE_TICKS)
  ) u_age (
    .clk         (CORE_CLK),
    .rst_n       (rst_n_i),
    .age_en      (s_r.ctl1[C1_AGE_EN]),
    .fast_en     (s_r.ctl1[C1_FAST_AGE]),
    .link_age_en (s_r.ctl1[C1_LINK_AGE]),
    .link_up     (PORT_LINK_UP),
    .age_pass    (AGE_PASS),
    .flush_all   (AGE_FLUSH_ALL)
  );

  // Output queue scheduler
  wfq_sched u_wfq (
    .clk         (CORE_CLK),
    .rst_n       (rst_n_i),
    .wfq_en      (s_r.ctl2[C2_WFQ]),
    .q_ready     (TXQ_READY),
    .slot        (TXQ_SLOT),
    .grant_valid (TXQ_GRANT_VALID),
    .grant_q     (TXQ_GRANT_SEL)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n_i);

  property p_pass_all;
    RX_FRAME_VALID && RX_FRAME_BAD && !RX_IS_PAUSE && !s_r.ctl1[C1_LEN_CHK]
      && s_r.ctl1[C1_PASS_ALL] && SNIFFER_ACTIVE |=> RX_FORWARD && !RX_DROP;
  endproperty
  a_pass_all: assert property (p_pass_all) else $error("bad frame not passed");
  property p_bad_drop;
    RX_FRAME_VALID && RX_FRAME_BAD && !SNIFFER_ACTIVE |=> RX_DROP && !RX_FORWARD;
  endproperty
  a_bad_drop: assert property (p_bad_drop) else $error("bad frame forwarded");
  property p_tx_pause;
    TX_PAUSE_GEN |-> $past(TX_PAUSE_REQ) && $past(s_r.ctl1[C1_TXFC]);
  endproperty
  a_tx_pause: assert property (p_tx_pause) else $error("pause sent while disabled");
  property p_rx_pause;
    RX_PAUSE_HONOR |-> $past(RX_FRAME_VALID && RX_IS_PAUSE) && $past(s_r.ctl1[C1_RXFC]);
  endproperty
  a_rx_pause: assert property (p_rx_pause) else $error("pause honoured while off");
  property p_len_chk;
    RX_FRAME_VALID && s_r.ctl1[C1_LEN_CHK] && RX_LEN_FIELD < 16'h05DC
      && RX_LEN_FIELD != RX_ACT_LEN |=> RX_DROP && !RX_TO_HOST;
  endproperty
  a_len_chk: assert property (p_len_chk) else $error("length mismatch not dropped");
  property p_pause_filter;
    RX_FRAME_VALID && RX_IS_PAUSE && !s_r.ctl1[C1_PASS_PAUSE] |=> RX_DROP;
  endproperty
  a_pause_filter: assert property (p_pause_filter) else $error("pause not filtered");
  property p_vlan_wr;
    s_r.dp_wr2 |=> VLAN_EN == $past(HWDATA[15]) && MLD_SNOOP_EN == $past(HWDATA[13]);
  endproperty
  a_vlan_wr: assert property (p_vlan_wr) else $error("mode write not applied");
  property p_igmp;
    RX_FRAME_VALID && RX_IS_IGMP && s_r.ctl2[C2_IGMP] && !RX_FRAME_BAD && !RX_IS_PAUSE
      && !s_r.ctl1[C1_LEN_CHK] |=> RX_TO_HOST;
  endproperty
  a_igmp: assert property (p_igmp) else $error("igmp frame not sent to host");
  property p_mld_off;
    RX_TO_HOST |-> $past(RX_IS_IGMP && s_r.ctl2[C2_IGMP] || RX_IS_MLD && s_r.ctl2[C2_MLD]);
  endproperty
  a_mld_off: assert property (p_mld_off) else $error("snoop while disabled");
  property p_mld_opt;
    MLD_OPT_EN |-> s_r.ctl2[C2_MLD_OPT] && MLD_SNOOP_EN;
  endproperty
  a_mld_opt: assert property (p_mld_opt) else $error("mld option without enable");
  property p_read_back;
    addr_ph && !HWRITE && hit1 && !s_r.dp_wr1 |=> HRDATA == {16'h0000, s_r.ctl1};
  endproperty
  a_read_back: assert property (p_read_back) else $error("register read mismatch");
  // Every offered frame gets exactly one of forward or drop
  property p_one_verdict;
    RX_FRAME_VALID |=> RX_FORWARD ^ RX_DROP;
  endproperty
  a_one_verdict: assert property (p_one_verdict) else $error("frame verdict not unique");
  // No verdict pulse without an offered frame
  property p_no_verdict;
    !RX_FRAME_VALID |=> !RX_FORWARD && !RX_DROP && !RX_TO_HOST && !RX_PAUSE_HONOR;
  endproperty
  a_no_verdict: assert property (p_no_verdict) else $error("verdict without frame");
  // A data phase write to control one lands on the next edge
  property p_ctl1_wr;
    s_r.dp_wr1 |=> s_r.ctl1 == $past(HWDATA[15:0]);
  endproperty
  a_ctl1_wr: assert property (p_ctl1_wr) else $error("control one write lost");
  c_drop: cover property (RX_DROP);
  c_wr_rd: cover property (s_r.dp_wr1 ##2 addr_ph && !HWRITE && hit1);
endmodule : switch_global_control_regs

// *** verification/switch_global_control_regs_tb_top.sv ***
`timescale 1ns/10ps
module switch_global_control_regs_tb_top;
  import sgc_pkg::*;
  // ==========================================================
  // Shortened aging counts in microsecond ticks, and register addresses
  localparam int          NORM_T = 40;
  localparam int          FAST_T = 8;
  localparam int          LINK_T = 5;
  localparam logic [31:0] A_ONE  = {CTL1_IDX, 2'b00};
  localparam logic [31:0] A_TWO  = {CTL2_IDX, 2'b00};
  logic        CORE_CLK, RST_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, SNIFFER_ACTIVE;
  logic [31:0] HADDR, HWDATA, HRDATA, rnd, rd;
  logic [1:0]  HTRANS, PORT_LINK_UP, TXQ_GRANT_SEL;
  logic [2:0]  HSIZE;
  logic        RX_FRAME_VALID, RX_FRAME_BAD, RX_IS_PAUSE, RX_IS_IGMP, RX_IS_MLD;
  logic [15:0] RX_LEN_FIELD, RX_ACT_LEN, c1, c2, lf, al;
  logic        RX_FORWARD, RX_DROP, RX_TO_HOST, RX_PAUSE_HONOR, TX_PAUSE_REQ, TX_PAUSE_GEN;
  logic        AGGR_BACKOFF_EN, VLAN_EN, MLD_SNOOP_EN, MLD_OPT_EN, AGE_PASS, AGE_FLUSH_ALL;
  logic [3:0]  TXQ_READY, ex, m;
  logic        TXQ_SLOT, TXQ_GRANT_VALID;
  int          fail_count, checks_done, n, cnt[4];

  // Single slave: its ready is the bus ready
  assign HREADY = HREADYOUT;

  switch_global_control_regs #(
    .NORMAL_AGE_TICKS(NORM_T), .FAST_AGE_TICKS(FAST_T), .LINK_AGE_TICKS(LINK_T)
  ) u_switch_global_control_regs (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .RX_FRAME_VALID(RX_FRAME_VALID), .RX_FRAME_BAD(RX_FRAME_BAD), .RX_IS_PAUSE(RX_IS_PAUSE),
    .RX_IS_IGMP(RX_IS_IGMP), .RX_IS_MLD(RX_IS_MLD), .RX_LEN_FIELD(RX_LEN_FIELD),
    .RX_ACT_LEN(RX_ACT_LEN), .SNIFFER_ACTIVE(SNIFFER_ACTIVE), .RX_FORWARD(RX_FORWARD),
    .RX_DROP(RX_DROP), .RX_TO_HOST(RX_TO_HOST), .RX_PAUSE_HONOR(RX_PAUSE_HONOR),
    .TX_PAUSE_REQ(TX_PAUSE_REQ), .TX_PAUSE_GEN(TX_PAUSE_GEN),
    .AGGR_BACKOFF_EN(AGGR_BACKOFF_EN), .VLAN_EN(VLAN_EN), .MLD_SNOOP_EN(MLD_SNOOP_EN),
    .MLD_OPT_EN(MLD_OPT_EN), .PORT_LINK_UP(PORT_LINK_UP), .AGE_PASS(AGE_PASS),
    .AGE_FLUSH_ALL(AGE_FLUSH_ALL), .TXQ_READY(TXQ_READY), .TXQ_SLOT(TXQ_SLOT),
    .TXQ_GRANT_VALID(TXQ_GRANT_VALID), .TXQ_GRANT_SEL(TXQ_GRANT_SEL)
  );

  // ==========================================================
  // Clock, 40 ns period
  initial begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end

  // Thirty-two shifts per call so that successive draws are unrelated
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    for (int i = 0; i < 32; i++) begin
      x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    end
    return x;
  endfunction : lfsr

  // Expected frame outcome: forward, drop, to host, pause honoured
  function automatic logic [3:0] verdict(input logic [15:0] k1, input logic [15:0] k2,
                                         input logic [4:0] q, input logic [15:0] fl,
                                         input logic [15:0] fa);
    logic drop;
    drop = (k1[C1_LEN_CHK] & (fl < MAX_LEN_FIELD) & (fl != fa))
         | (q[0] & !(k1[C1_PASS_ALL] & q[4])) | (q[1] & !k1[C1_PASS_PAUSE]);
    return {!drop, drop, !drop & ((q[2] & k2[C2_IGMP]) | (q[3] & k2[C2_MLD])),
            q[1] & k1[C1_RXFC]};
  endfunction : verdict

  // Comparisons of single flags and of whole words
  task automatic chk_flag(input string nm, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_flag

  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_val

  // One single AHB-Lite transfer; called just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat);
    HSEL   <= 1'b1;
    HADDR  <= a;
    HWRITE <= wr;
    HTRANS <= 2'b10;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'b00;
    HWDATA <= wd;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    rdat = HRDATA;
  endtask : bus

  // Program both registers, read them back and check the mode levels
  task automatic set_regs(input logic [15:0] k1, input logic [15:0] k2);
    bus(1'b1, A_ONE, {16'h0000, k1}, rd);
    bus(1'b1, A_TWO, {16'h0000, k2}, rd); // no VLAN table behind this block to fill first
    bus(1'b0, A_ONE, 32'h0000_0000, rd);
    chk_val("ctl_one", {16'h0000, k1}, rd);
    bus(1'b0, A_TWO, 32'h0000_0000, rd);
    chk_val("ctl_two", {16'h0000, k2 & CTL2_MASK}, rd);
    c1 = k1;
    c2 = k2 & CTL2_MASK;
    chk_flag("aggr_backoff", c1[C1_AGGR_BO], AGGR_BACKOFF_EN);
    chk_flag("vlan", c2[C2_VLAN], VLAN_EN);
    chk_flag("mld_snoop", c2[C2_MLD], MLD_SNOOP_EN);
    chk_flag("mld_opt", c2[C2_MLD] & c2[C2_MLD_OPT], MLD_OPT_EN);
  endtask : set_regs

  // Wait for an aging pulse (which=0) or a flush pulse (which=1), bounded
  task automatic wait_hi(input logic which, input int lim, output int cyc);
    cyc = 0;
    do begin
      @(posedge CORE_CLK);
      cyc++;
    end while (((which ? AGE_FLUSH_ALL : AGE_PASS) !== 1'b1) && cyc < lim);
  endtask : wait_hi

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // Watchdog against a hung handshake or a missing pulse
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    fail_count++;
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rnd = 32'h1941;
    fail_count = 0;
    checks_done = 0;
    {RST_N, HSEL, HWRITE, HADDR, HWDATA, HTRANS} = '0;
    HSIZE = 3'b010;
    {RX_FRAME_VALID, RX_FRAME_BAD, RX_IS_PAUSE, RX_IS_IGMP, RX_IS_MLD} = '0;
    {RX_LEN_FIELD, RX_ACT_LEN, SNIFFER_ACTIVE, TX_PAUSE_REQ, TXQ_READY, TXQ_SLOT} = '0;
    PORT_LINK_UP = 2'b11;
    repeat (5) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    // Reset values, unmapped and misaligned places
    bus(1'b0, A_ONE, 32'h0, rd);
    chk_val("ctl_one_rst", {16'h0000, CTL1_RESET}, rd);
    bus(1'b0, A_TWO, 32'h0, rd);
    chk_val("ctl_two_rst", {16'h0000, CTL2_RESET}, rd);
    bus(1'b1, 32'h0000_000C, 32'hFFFF_FFFF, rd);
    bus(1'b0, 32'h0000_000C, 32'h0, rd);
    chk_val("unmapped", 32'h0, rd);
    bus(1'b0, A_ONE + 32'h1, 32'h0, rd);
    chk_val("misaligned", 32'h0, rd);
    chk_flag("hresp", 1'b0, HRESP);
    // Random settings with frames and pause requests; first two are corners
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      set_regs(k == 0 ? 16'h8808 : (k == 1 ? 16'h3400 : rnd[15:0]), rnd[31:16]);
      for (int f = 0; f < 12; f++) begin
        rnd = lfsr(rnd);
        lf = (rnd[7:6] == 2'd0) ? MAX_LEN_FIELD - 16'h1 :
             (rnd[7:6] == 2'd1) ? MAX_LEN_FIELD : rnd[31:16];
        al = rnd[8] ? lf : lf + 16'h1;
        {SNIFFER_ACTIVE, RX_IS_MLD, RX_IS_IGMP, RX_IS_PAUSE, RX_FRAME_BAD} <= rnd[4:0];
        {RX_FRAME_VALID, TX_PAUSE_REQ, RX_LEN_FIELD, RX_ACT_LEN} <= {1'b1, rnd[5], lf, al};
        ex = verdict(c1, c2, rnd[4:0], lf, al);
        @(posedge CORE_CLK);
        RX_FRAME_VALID <= 1'b0;
        @(posedge CORE_CLK);
        chk_flag("forward", ex[3], RX_FORWARD);
        chk_flag("drop", ex[2], RX_DROP);
        chk_flag("to_host", ex[1], RX_TO_HOST);
        chk_flag("pause_honor", ex[0], RX_PAUSE_HONOR);
        chk_flag("pause_gen", rnd[5] & c1[C1_TXFC], TX_PAUSE_GEN);
      end
    end
    // Strict priority: highest ready queue wins, none ready gives no grant
    set_regs(16'h3400, 16'h0000);
    for (int q = 0; q < 10; q++) begin
      rnd = lfsr(rnd);
      m = (q == 0) ? 4'h0 : rnd[3:0];
      TXQ_READY <= m;
      TXQ_SLOT <= 1'b1;
      @(posedge CORE_CLK);
      TXQ_SLOT <= 1'b0;
      @(posedge CORE_CLK);
      chk_flag("grant_valid", |m, TXQ_GRANT_VALID);
      if (|m) chk_val("grant_sel", m[3] ? 3 : m[2] ? 2 : m[1] ? 1 : 0, TXQ_GRANT_SEL);
    end
    // Weighted mode, all queues busy: one full round after a warm-up round
    set_regs(16'h3400, 16'h0800);
    TXQ_READY <= 4'hF;
    cnt = '{default: 0};
    for (int s = 0; s < 30; s++) begin
      TXQ_SLOT <= 1'b1;
      @(posedge CORE_CLK);
      TXQ_SLOT <= 1'b0;
      @(posedge CORE_CLK);
      if (s >= 15 && TXQ_GRANT_VALID === 1'b1) cnt[TXQ_GRANT_SEL]++;
    end
    for (int i = 0; i < 4; i++) chk_val("wfq_share", {28'h0, WFQ_WEIGHT[i]}, cnt[i]);
    // Aging periods: fast, then normal, then disabled
    set_regs(16'h3600, 16'h0000);
    wait_hi(1'b0, FAST_T * 25 + 50, n);
    wait_hi(1'b0, FAST_T * 25 + 50, n);
    chk_val("fast_period", FAST_T * 25, n);
    set_regs(16'h3400, 16'h0000);
    wait_hi(1'b0, NORM_T * 25 + 50, n);
    wait_hi(1'b0, NORM_T * 25 + 50, n);
    chk_val("normal_period", NORM_T * 25, n);
    set_regs(16'h3000, 16'h0000);
    wait_hi(1'b0, NORM_T * 25 + 100, n);
    chk_val("aging_off", NORM_T * 25 + 100, n);
    // Link loss: flush, one short pass, then the normal period again
    set_regs(16'h3401, 16'h0000);
    PORT_LINK_UP <= 2'b10;
    wait_hi(1'b1, 4, n);
    chk_flag("flush_all", 1'b1, AGE_FLUSH_ALL);
    wait_hi(1'b0, LINK_T * 25 + 4, n);
    chk_flag("link_pass", 1'b1, AGE_PASS);
    wait_hi(1'b0, NORM_T * 25 + 50, n);
    chk_val("after_link", NORM_T * 25, n);
    wrap_up();
  end
endmodule : switch_global_control_regs_tb_top
